// *** fpm_cfg.svh ***
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define FPM_IDX_LED_SELECT    8'h14
`define FPM_IDX_A_CONTROL     8'h42
`define FPM_IDX_A_CONNECTION  8'h43
`define FPM_IDX_B_CONTROL     8'h44
`define FPM_IDX_B_CONNECTION  8'h45
`define FPM_IDX_GLOBAL_BUFFER 8'h58

// ==========================================================
// Path connection word encodings
`define FPM_CONN_NORMAL       16'hada5
`define FPM_CONN_BPF_BYPASS   16'hae65
`define FPM_CONN_FULL_BYPASS  16'hb065

// ==========================================================
// Field positions
`define FPM_SETUP_MSB         15
`define FPM_SETUP_LSB         10
`define FPM_GAIN_BIT          9
`define FPM_INT_BUF_BIT       7
`define FPM_VREF_MSB          5
`define FPM_VREF_LSB          4
`define FPM_MASTER_BUF_BIT    7
`define FPM_LED_FIELD_WIDTH   2

// ==========================================================
// Reset values
`define FPM_RST_CONTROL       16'h1c30
`define FPM_RST_CONNECTION    16'hada5
`define FPM_RST_GLOBAL        16'h0000
`define FPM_RST_LED_SELECT    16'h0005
`define FPM_SETUP_IGNORED     6'h00
`define FPM_RST_SETUP         6'h07
`define FPM_RST_VREF          2'h3
`define FPM_RST_PD_CONNECT    2'h3
`define FPM_LED_DISCONNECTED  2'h0

`endif

// *** fpm_pkg.sv ***
`default_nettype none

package fpm_pkg;

	// ==========================================================
	// Bus handshake states
	typedef enum logic [0:0] {
		FPM_BUS_IDLE = 1'b0,
		FPM_BUS_ACK  = 1'b1
	} fpm_bus_e;

	// ==========================================================
	// Decoded receive path of one slot
	typedef enum logic [1:0] {
		FPM_PATH_NORMAL      = 2'b00,
		FPM_PATH_BPF_BYPASS  = 2'b01,
		FPM_PATH_FULL_BYPASS = 2'b10,
		FPM_PATH_OTHER       = 2'b11
	} fpm_path_e;

	// Register select produced by the address decoder
	typedef enum logic [2:0] {
		FPM_SEL_NONE   = 3'b000,
		FPM_SEL_A_CTRL = 3'b001,
		FPM_SEL_A_CONN = 3'b010,
		FPM_SEL_B_CTRL = 3'b011,
		FPM_SEL_B_CONN = 3'b100,
		FPM_SEL_GLOBAL = 3'b101,
		FPM_SEL_LED    = 3'b110
	} fpm_sel_e;

	// ==========================================================
	// Whole module state; index 0 is slot A, index 1 slot B
	typedef struct packed {
		fpm_bus_e          busState;
		logic [31:0]       readData;
		logic [1:0][15:0]  control;
		logic [1:0][15:0]  connection;
		logic [15:0]       globalBuffer;
		logic [15:0]       ledSelect;
		logic [1:0]        bpfBypass;
		logic [1:0]        intBypass;
		logic [1:0]        bufferMode;
		logic [1:0]        bufferGain;
		logic [1:0][5:0]   intSetup;
		logic [1:0][1:0]   vrefSelect;
		logic [1:0]        pulseConnect;
		logic [1:0]        pdConnect;
		logic [1:0]        ledEnable;
	} fpm_state_s;

endpackage

`default_nettype wire

// *** fpm_path_config.sv ***
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"

module fpm_path_config (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [9:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [3:0]        byteenable,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  wire logic [1:0]        ledPulseTiming,
	output logic      [1:0]        bandPassFilterBypass,
	output logic      [1:0]        integratorBypass,
	output logic      [1:0]        integratorBufferSelect,
	output logic      [1:0]        bufferGainSelect,
	output logic      [1:0][5:0]   integratorSetup,
	output logic      [1:0][1:0]   amplifierReferenceSelect,
	output logic      [1:0]        pulseConnectActive,
	output logic      [1:0]        photodiodeConnect,
	output logic      [1:0]        ledPulseEnable
);

	// ==========================================================
	// Decoding helpers
	// Only whole-word index matches select; low address bits are ignored
	function automatic fpm_pkg::fpm_sel_e regSelect(input logic [9:0] addr);
		fpm_pkg::fpm_sel_e sel;
		sel = fpm_pkg::FPM_SEL_NONE;
		case (addr[9:2])
			`FPM_IDX_A_CONTROL:     sel = fpm_pkg::FPM_SEL_A_CTRL;
			`FPM_IDX_A_CONNECTION:  sel = fpm_pkg::FPM_SEL_A_CONN;
			`FPM_IDX_B_CONTROL:     sel = fpm_pkg::FPM_SEL_B_CTRL;
			`FPM_IDX_B_CONNECTION:  sel = fpm_pkg::FPM_SEL_B_CONN;
			`FPM_IDX_GLOBAL_BUFFER: sel = fpm_pkg::FPM_SEL_GLOBAL;
			`FPM_IDX_LED_SELECT:    sel = fpm_pkg::FPM_SEL_LED;
			default:                sel = fpm_pkg::FPM_SEL_NONE;
		endcase
		return sel;
	endfunction

	// Unknown words fall to OTHER, which keeps the full chain in place
	function automatic fpm_pkg::fpm_path_e pathDecode(input logic [15:0] word);
		fpm_pkg::fpm_path_e mode;
		mode = fpm_pkg::FPM_PATH_OTHER;
		case (word)
			`FPM_CONN_NORMAL:      mode = fpm_pkg::FPM_PATH_NORMAL;
			`FPM_CONN_BPF_BYPASS:  mode = fpm_pkg::FPM_PATH_BPF_BYPASS;
			`FPM_CONN_FULL_BYPASS: mode = fpm_pkg::FPM_PATH_FULL_BYPASS;
			default:               mode = fpm_pkg::FPM_PATH_OTHER;
		endcase
		return mode;
	endfunction

	// Merge the two low byte lanes of a write into a stored word
	function automatic logic [15:0] laneMerge(input logic [15:0] old,
	                                          input logic [31:0] data,
	                                          input logic [3:0]  be);
		logic [15:0] merged;
		merged = old;
		if (be[0]) begin
			merged[7:0] = data[7:0];
		end
		if (be[1]) begin
			merged[15:8] = data[15:8];
		end
		return merged;
	endfunction

	// ==========================================================
	// State
	fpm_pkg::fpm_state_s state_q;
	fpm_pkg::fpm_state_s state_d;
	fpm_pkg::fpm_sel_e   sel;
	logic                request;

	assign sel     = regSelect(address);
	assign request = read | write;

	// One wait cycle per access; released in the acknowledge state
	assign waitrequest = request & (state_q.busState != fpm_pkg::FPM_BUS_ACK);

	// ==========================================================
	// Next state: bus slave, register file and path decode
	always_comb begin
		fpm_pkg::fpm_path_e mode;
		logic [15:0]        word;
		logic               ledOff;
		mode    = fpm_pkg::FPM_PATH_OTHER;
		word    = 16'h0000;
		ledOff  = 1'b0;
		state_d = state_q;

		// Bus handshake and read capture
		case (state_q.busState)
			fpm_pkg::FPM_BUS_IDLE: begin
				if (request) begin
					state_d.busState = fpm_pkg::FPM_BUS_ACK;
					state_d.readData = 32'h0000_0000;
					case (sel)
						fpm_pkg::FPM_SEL_A_CTRL: word = state_q.control[0];
						fpm_pkg::FPM_SEL_A_CONN: word = state_q.connection[0];
						fpm_pkg::FPM_SEL_B_CTRL: word = state_q.control[1];
						fpm_pkg::FPM_SEL_B_CONN: word = state_q.connection[1];
						fpm_pkg::FPM_SEL_GLOBAL: word = state_q.globalBuffer;
						fpm_pkg::FPM_SEL_LED:    word = state_q.ledSelect;
						default:                 word = 16'h0000;
					endcase
					if (read) begin
						state_d.readData = {16'h0000, word};
					end
				end
			end
			fpm_pkg::FPM_BUS_ACK: begin
				state_d.busState = fpm_pkg::FPM_BUS_IDLE;
				// Write commits only on the edge where waitrequest is low
				if (write) begin
					case (sel)
						fpm_pkg::FPM_SEL_A_CTRL:
							state_d.control[0] = laneMerge(state_q.control[0],
								writedata, byteenable);
						fpm_pkg::FPM_SEL_A_CONN:
							state_d.connection[0] = laneMerge(state_q.connection[0],
								writedata, byteenable);
						fpm_pkg::FPM_SEL_B_CTRL:
							state_d.control[1] = laneMerge(state_q.control[1],
								writedata, byteenable);
						fpm_pkg::FPM_SEL_B_CONN:
							state_d.connection[1] = laneMerge(state_q.connection[1],
								writedata, byteenable);
						fpm_pkg::FPM_SEL_GLOBAL:
							state_d.globalBuffer = laneMerge(state_q.globalBuffer,
								writedata, byteenable);
						fpm_pkg::FPM_SEL_LED:
							state_d.ledSelect = laneMerge(state_q.ledSelect,
								writedata, byteenable);
						default: begin
							// Unmapped writes are dropped
						end
					endcase
				end
			end
			default: begin
				state_d.busState = fpm_pkg::FPM_BUS_IDLE;
			end
		endcase

		// Decode from the next register values so outputs move with the write edge
		for (int i = 0; i < 2; i++) begin
			mode   = pathDecode(state_d.connection[i]);
			ledOff = (state_d.ledSelect[i*`FPM_LED_FIELD_WIDTH +: `FPM_LED_FIELD_WIDTH]
				== `FPM_LED_DISCONNECTED);
			state_d.bpfBypass[i] = (mode == fpm_pkg::FPM_PATH_BPF_BYPASS) ||
				(mode == fpm_pkg::FPM_PATH_FULL_BYPASS);
			state_d.intBypass[i] = (mode == fpm_pkg::FPM_PATH_FULL_BYPASS);
			// Buffer use needs slot bit, master enable and the buffer-capable path
			state_d.bufferMode[i] = state_d.control[i][`FPM_INT_BUF_BIT] &&
				state_d.globalBuffer[`FPM_MASTER_BUF_BIT] &&
				(mode == fpm_pkg::FPM_PATH_BPF_BYPASS);
			state_d.bufferGain[i] = state_d.control[i][`FPM_GAIN_BIT];
			// Setup field only reaches the integrator with the normal connection word
			if (mode == fpm_pkg::FPM_PATH_NORMAL) begin
				state_d.intSetup[i] =
					state_d.control[i][`FPM_SETUP_MSB:`FPM_SETUP_LSB];
			end else begin
				state_d.intSetup[i] = `FPM_SETUP_IGNORED;
			end
			state_d.vrefSelect[i] = state_d.control[i][`FPM_VREF_MSB:`FPM_VREF_LSB];
			state_d.pulseConnect[i] = (mode == fpm_pkg::FPM_PATH_NORMAL) && ledOff;
			// Pulse timing moves to the photodiode switch, LED stays dark
			if (state_d.pulseConnect[i]) begin
				state_d.pdConnect[i] = ledPulseTiming[i];
				state_d.ledEnable[i] = 1'b0;
			end else begin
				state_d.pdConnect[i] = 1'b1;
				state_d.ledEnable[i] = ledPulseTiming[i] && !ledOff;
			end
		end
	end

	// ==========================================================
	// State register; reset values match the normal sampling setup
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q.busState      <= fpm_pkg::FPM_BUS_IDLE;
			state_q.readData      <= 32'h0000_0000;
			state_q.control       <= {`FPM_RST_CONTROL, `FPM_RST_CONTROL};
			state_q.connection    <= {`FPM_RST_CONNECTION, `FPM_RST_CONNECTION};
			state_q.globalBuffer  <= `FPM_RST_GLOBAL;
			state_q.ledSelect     <= `FPM_RST_LED_SELECT;
			state_q.bpfBypass     <= 2'h0;
			state_q.intBypass     <= 2'h0;
			state_q.bufferMode    <= 2'h0;
			state_q.bufferGain    <= 2'h0;
			state_q.intSetup      <= {2{`FPM_RST_SETUP}};
			state_q.vrefSelect    <= {2{`FPM_RST_VREF}};
			state_q.pulseConnect  <= 2'h0;
			state_q.pdConnect     <= `FPM_RST_PD_CONNECT;
			state_q.ledEnable     <= 2'h0;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign readdata                 = state_q.readData;
	assign bandPassFilterBypass     = state_q.bpfBypass;
	assign integratorBypass         = state_q.intBypass;
	assign integratorBufferSelect   = state_q.bufferMode;
	assign bufferGainSelect         = state_q.bufferGain;
	assign integratorSetup          = state_q.intSetup;
	assign amplifierReferenceSelect = state_q.vrefSelect;
	assign pulseConnectActive       = state_q.pulseConnect;
	assign photodiodeConnect        = state_q.pdConnect;
	assign ledPulseEnable           = state_q.ledEnable;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_bus_ack_next: assert property (
		(request && state_q.busState == fpm_pkg::FPM_BUS_IDLE)
		|-> waitrequest ##1 !waitrequest)
		else $error("Access not acknowledged after one wait cycle");

	a_write_update: assert property (
		(write && !waitrequest && sel == fpm_pkg::FPM_SEL_A_CTRL && byteenable[1:0] == 2'b11)
		|=> (state_q.control[0] == $past(writedata[15:0])))
		else $error("Slot A control write not stored");

	a_normal_path: assert property (
		(state_q.connection[0] == `FPM_CONN_NORMAL)
		|-> !bandPassFilterBypass[0] && !integratorBypass[0])
		else $error("Normal word bypassed a stage");

	a_bpf_only: assert property (
		(state_q.connection[0] == `FPM_CONN_BPF_BYPASS)
		|-> bandPassFilterBypass[0] && !integratorBypass[0])
		else $error("Filter-only bypass decoded wrongly");

	a_slot_b_full: assert property (
		(state_q.connection[1] == `FPM_CONN_FULL_BYPASS)
		|-> bandPassFilterBypass[1] && integratorBypass[1] && !integratorBufferSelect[1])
		else $error("Slot B full bypass decoded wrongly");

	a_gain_follow: assert property (
		bufferGainSelect == {state_q.control[1][`FPM_GAIN_BIT],
			state_q.control[0][`FPM_GAIN_BIT]})
		else $error("Buffer gain does not follow control bit");

	a_buffer_gate: assert property (
		integratorBufferSelect[0]
		|-> state_q.globalBuffer[`FPM_MASTER_BUF_BIT] &&
			state_q.control[0][`FPM_INT_BUF_BIT] &&
			state_q.connection[0] == `FPM_CONN_BPF_BYPASS)
		else $error("Buffer mode without its enables");

	a_setup_ignored: assert property (
		(state_q.connection[1] != `FPM_CONN_NORMAL) |-> (integratorSetup[1] == 6'h00))
		else $error("Setup field passed in bypass mode");

	a_vref_follow: assert property (
		amplifierReferenceSelect[0] == state_q.control[0][`FPM_VREF_MSB:`FPM_VREF_LSB])
		else $error("Reference select does not follow control");

	a_pulse_gate: assert property (
		(pulseConnectActive[0] && $past(pulseConnectActive[0]))
		|-> (photodiodeConnect[0] == $past(ledPulseTiming[0])) && !ledPulseEnable[0])
		else $error("Pulse connect gating wrong");

	a_pulse_enable: assert property (
		pulseConnectActive[1] == ((state_q.connection[1] == `FPM_CONN_NORMAL) &&
			(state_q.ledSelect[3:2] == `FPM_LED_DISCONNECTED)))
		else $error("Pulse connect enable mismatch");

	a_slot_a_full: assert property (
		(state_q.connection[0] == `FPM_CONN_FULL_BYPASS)
		|-> bandPassFilterBypass[0] && integratorBypass[0] && !integratorBufferSelect[0])
		else $error("Slot A full bypass decoded wrongly");

	a_slot_b_normal: assert property (
		(state_q.connection[1] == `FPM_CONN_NORMAL)
		|-> !bandPassFilterBypass[1] && !integratorBypass[1])
		else $error("Slot B normal word bypassed a stage");

	a_slot_b_bpf: assert property (
		(state_q.connection[1] == `FPM_CONN_BPF_BYPASS)
		|-> bandPassFilterBypass[1] && !integratorBypass[1])
		else $error("Slot B filter-only bypass decoded wrongly");

	// Forward direction: all three enables must really switch the buffer on
	a_buffer_on: assert property (
		(state_q.control[0][`FPM_INT_BUF_BIT] &&
			state_q.globalBuffer[`FPM_MASTER_BUF_BIT] &&
			state_q.connection[0] == `FPM_CONN_BPF_BYPASS)
		|-> integratorBufferSelect[0])
		else $error("Slot A buffer mode not applied");

	a_buffer_gate_b: assert property (
		integratorBufferSelect[1]
		|-> state_q.globalBuffer[`FPM_MASTER_BUF_BIT] &&
			state_q.control[1][`FPM_INT_BUF_BIT] &&
			state_q.connection[1] == `FPM_CONN_BPF_BYPASS)
		else $error("Slot B buffer mode without its enables");

	a_setup_normal: assert property (
		(state_q.connection[0] == `FPM_CONN_NORMAL)
		|-> (integratorSetup[0] == state_q.control[0][`FPM_SETUP_MSB:`FPM_SETUP_LSB]))
		else $error("Setup field not passed in normal mode");

	a_vref_slot_b: assert property (
		amplifierReferenceSelect[1] == state_q.control[1][`FPM_VREF_MSB:`FPM_VREF_LSB])
		else $error("Slot B reference select does not follow control");

	a_pulse_gate_b: assert property (
		pulseConnectActive[1]
		|-> (photodiodeConnect[1] == $past(ledPulseTiming[1])) && !ledPulseEnable[1])
		else $error("Slot B pulse connect gating wrong");

	a_pd_connected: assert property (
		!pulseConnectActive[0] |-> photodiodeConnect[0])
		else $error("Photodiode cut outside pulse connect");

	a_pulse_enable_a: assert property (
		pulseConnectActive[0] == ((state_q.connection[0] == `FPM_CONN_NORMAL) &&
			(state_q.ledSelect[1:0] == `FPM_LED_DISCONNECTED)))
		else $error("Slot A pulse connect enable mismatch");

	c_write_done: cover property (write && !waitrequest);
	c_read_done:  cover property (read && !waitrequest && readdata != 32'h0);
	c_buffer_on:  cover property (integratorBufferSelect[0]);
	c_pulse_on:   cover property (pulseConnectActive[1] && photodiodeConnect[1]);
	c_full_bypass: cover property (integratorBypass[1] && bandPassFilterBypass[1]);

endmodule

`default_nettype wire

// *** test_fpm_path_config.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"

module test_fpm_path_config;
	logic             clk;
	logic             reset;
	logic [9:0]       address;
	logic             read;
	logic             write;
	logic [3:0]       byteenable;
	logic [31:0]      writedata;
	logic [31:0]      readdata;
	logic             waitrequest;
	logic [1:0]       ledPulseTiming;
	logic [1:0]       bpfBypass;
	logic [1:0]       intBypass;
	logic [1:0]       bufSelect;
	logic [1:0]       gainSelect;
	logic [1:0][5:0]  intSetup;
	logic [1:0][1:0]  refSelect;
	logic [1:0]       pulseActive;
	logic [1:0]       pdConnect;
	logic [1:0]       ledEnable;
	int               miscompares;
	int               testsRun;
	logic [15:0]      words [3];
	logic [7:0]       ctrlIdx;
	logic [7:0]       connIdx;
	logic [15:0]      w;
	logic [31:0]      scratch;

	// ==========================================================
	// Device under test
	fpm_path_config i_dut (
		.clk                      (clk),
		.reset                    (reset),
		.address                  (address),
		.read                     (read),
		.write                    (write),
		.byteenable               (byteenable),
		.writedata                (writedata),
		.readdata                 (readdata),
		.waitrequest              (waitrequest),
		.ledPulseTiming           (ledPulseTiming),
		.bandPassFilterBypass     (bpfBypass),
		.integratorBypass         (intBypass),
		.integratorBufferSelect   (bufSelect),
		.bufferGainSelect         (gainSelect),
		.integratorSetup          (intSetup),
		.amplifierReferenceSelect (refSelect),
		.pulseConnectActive       (pulseActive),
		.photodiodeConnect        (pdConnect),
		.ledPulseEnable           (ledEnable)
	);

	// Free running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Verdict, reached from the main sequence and from timeouts
	task automatic tally_and_finish();
		if (miscompares == 0 && testsRun > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Register read data comparison
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
		end
	endtask

	// Control output comparison
	task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t out got %h exp %h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus_access(input logic isWrite, input logic [7:0] idx,
		input logic [15:0] data, input logic [3:0] be, output logic [31:0] rdata);
		int n;
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {16'h0000, data};
		byteenable <= be;
		read <= ~isWrite;
		write <= isWrite;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			miscompares++;
			$display("MISMATCH %0t bus timeout", $time);
			tally_and_finish();
		end
		// Let the committing edge land before outputs are looked at
		#1;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] data);
		logic [31:0] unused;
		bus_access(1'b1, idx, data, 4'h3, unused);
	endtask

	task automatic check_read(input logic [7:0] idx, input logic [15:0] exp);
		logic [31:0] r;
		bus_access(1'b0, idx, 16'h0000, 4'h3, r);
		check_reg(r, {16'h0000, exp});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		address = 10'h000;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = 32'h00000000;
		ledPulseTiming = 2'h0;
		miscompares = 0;
		testsRun = 0;
		words = '{`FPM_CONN_NORMAL, `FPM_CONN_BPF_BYPASS, `FPM_CONN_FULL_BYPASS};
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// Reset contents and the static outputs they decode to
		check_read(`FPM_IDX_LED_SELECT, `FPM_RST_LED_SELECT);
		check_read(`FPM_IDX_A_CONTROL, `FPM_RST_CONTROL);
		check_read(`FPM_IDX_B_CONNECTION, `FPM_RST_CONNECTION);
		check_read(`FPM_IDX_GLOBAL_BUFFER, `FPM_RST_GLOBAL);
		check_out({2'h0, intSetup[0]}, {2'h0, `FPM_RST_SETUP});
		check_out({2'h0, intSetup[1]}, {2'h0, `FPM_RST_SETUP});
		check_out({refSelect, pdConnect, ledEnable}, 8'hfc);
		for (int s = 0; s < 2; s++) begin
			ctrlIdx = `FPM_IDX_A_CONTROL + 8'(2 * s);
			connIdx = `FPM_IDX_A_CONNECTION + 8'(2 * s);
			// Every connection word, bypass flags and setup field
			for (int k = 0; k < 3; k++) begin
				w = words[k];
				wr(connIdx, w);
				check_read(connIdx, w);
				check_out({6'h00, bpfBypass[s], intBypass[s]},
					{6'h00, w != `FPM_CONN_NORMAL, w == `FPM_CONN_FULL_BYPASS});
				check_out({2'h0, intSetup[s]}, (w == `FPM_CONN_NORMAL) ? 8'h07 : 8'h00);
			end
			// Buffer selection needs slot bit, master bit and word
			wr(connIdx, `FPM_CONN_BPF_BYPASS);
			wr(ctrlIdx, 16'h1cb0);
			check_out({7'h00, bufSelect[s]}, 8'h00);
			wr(`FPM_IDX_GLOBAL_BUFFER, 16'h0080);
			check_out({6'h00, bufSelect}, 8'(1 << s));
			wr(connIdx, `FPM_CONN_FULL_BYPASS);
			check_out({7'h00, bufSelect[s]}, 8'h00);
			wr(connIdx, `FPM_CONN_BPF_BYPASS);
			wr(ctrlIdx, 16'h1c30);
			check_out({7'h00, bufSelect[s]}, 8'h00);
			wr(`FPM_IDX_GLOBAL_BUFFER, 16'h0000);
			wr(connIdx, `FPM_CONN_NORMAL);
			// Gain bit and every reference code
			for (int v = 0; v < 4; v++) begin
				wr(ctrlIdx, 16'h1c00 | 16'(v << 4) | (v[0] ? 16'h0200 : 16'h0000));
				check_out({5'h00, gainSelect[s], refSelect[s]}, 8'(v | (v[0] << 2)));
			end
			// Low byte lane only
			// Last loop pass left 0x1e30; only bits 7:0 may change
			bus_access(1'b1, ctrlIdx, 16'hffff, 4'h1, scratch);
			check_read(ctrlIdx, 16'h1eff);
		end
		// Unmapped index: write dropped, read gives zero
		wr(8'h20, 16'h1234);
		check_read(8'h20, 16'h0000);
		// Pulse connect on slot A only
		wr(`FPM_IDX_LED_SELECT, 16'h0004);
		check_out({6'h00, pulseActive}, 8'h01);
		@(posedge clk);
		ledPulseTiming <= 2'b01;
		@(posedge clk);
		#1;
		check_out({4'h0, pdConnect, ledEnable}, 8'h0c);
		@(posedge clk);
		ledPulseTiming <= 2'b10;
		@(posedge clk);
		#1;
		check_out({4'h0, pdConnect, ledEnable}, 8'h0a);
		// Leaving the normal word ends pulse connect
		wr(`FPM_IDX_A_CONNECTION, `FPM_CONN_BPF_BYPASS);
		check_out({6'h00, pulseActive}, 8'h00);
		// Pulse connect on slot B, slot A LED field back on
		wr(`FPM_IDX_LED_SELECT, 16'h0001);
		check_out({6'h00, pulseActive}, 8'h02);
		check_out({4'h0, pdConnect, ledEnable}, 8'h0c);
		@(posedge clk);
		ledPulseTiming <= 2'b00;
		@(posedge clk);
		#1;
		check_out({4'h0, pdConnect, ledEnable}, 8'h04);
		tally_and_finish();
	end
endmodule

`default_nettype wire
